// >>> inc/pmbov_pkg.sv
package pmbov_pkg;

  // command codes
  localparam logic [7:0] CMD_OFFSET     = 8'h39;
  localparam logic [7:0] CMD_OV_LIMIT   = 8'h40;
  localparam logic [7:0] CMD_OV_ACTION  = 8'h41;
  localparam logic [7:0] PHASE_ALL      = 8'hFF;

  // current_sense_offset layout
  localparam int         EXP_MSB        = 15;
  localparam int         EXP_LSB        = 11;
  localparam int         MAN_MSB        = 10;
  localparam logic [4:0] EXP_RESET      = 5'h1C;

  // overvoltage_fault_action layout
  localparam int         ACT_MSB        = 7;
  localparam int         ACT_LSB        = 6;
  localparam int         RETRY_MSB      = 5;
  localparam int         RETRY_LSB      = 3;
  localparam int         WAIT_MSB       = 2;
  localparam logic [1:0] ACTION_IGNORE  = 2'h0;
  localparam logic [1:0] ACTION_INVALID = 2'h3;
  localparam logic [2:0] RETRY_LATCH    = 3'h0;
  localparam logic [2:0] RETRY_FOREVER  = 3'h7;

  // overvoltage hardware steps, per mille of the voltage command
  localparam logic [11:0] OV_RUN_MIN    = 12'd1050;
  localparam logic [11:0] OV_RUN_INC    = 12'd25;
  localparam int          OV_RUN_NUM    = 15;
  localparam logic [11:0] OV_OFF_MIN    = 12'd1100;
  localparam logic [11:0] OV_OFF_INC    = 12'd100;
  localparam int          OV_OFF_NUM    = 4;
  localparam logic [11:0] OV_MAX        = 12'd1400;
  localparam logic [31:0] PERMILLE      = 32'd1000;

  typedef enum logic [2:0] {
    PMBOV_OFF     = 3'b000,
    PMBOV_RISE    = 3'b001,
    PMBOV_CHECK   = 3'b010,
    PMBOV_ON      = 3'b011,
    PMBOV_WAIT    = 3'b100,
    PMBOV_LATCHED = 3'b101
  } pmbov_state_t;

  typedef struct packed {
    logic        write;
    logic [7:0]  code;
    logic [7:0]  phase;
    logic [15:0] data;
  } pmbov_cmd_t;

  typedef struct packed {
    logic        error;
    logic [15:0] data;
  } pmbov_rsp_t;

  typedef struct packed {
    logic byte_vout_ov;
    logic word_vout;
    logic overvoltage_threshold_field;
    logic cml_invalid_data;
  } pmbov_status_t;

endpackage

// >>> rtl/pmbov_core.sv
`timescale 1ns/1ps
// Summary of operation
// - offset exponent sits in bits 15:11, two's complement, fixed at 11100b.
// - offset mantissa sits in bits 10:0, reset value taken from storage.
// - out-of-range writes to the three commands flag invalid data, alert host.
// - offset writes keep full resolution when inside the supported range.
// - after reset or restore the offset takes a coarse supported value.
// - phase 00h to 03h makes offset access act on that one phase.
// - phase FFh write divides the offset by phase count into every phase.
// - phase FFh read returns phase zero offset times the phase count.
// - threshold is command 40h, word access, relative or absolute per mode.
// - trip point is always applied relative to the voltage command.
// - overvoltage monitoring runs from reset release, output on or off.
// - converting, round threshold up to 2.5% steps from 105% to 140%.
// - not converting, use 10% steps from 110% to 140%.
// - on fault set byte, word and vout status bits and alert the host.
// - action is command 41h, a single byte accessed with byte transfers.
// - bits 7:6 select ignore (00b), shutdown (01b, 10b); 11b is refused.
// - bits 5:3: 0 latches, 1..6 restart that often, 7 restarts forever.
// - bits 2:0 give the wait in rise times, zero meaning one.
// - no fault for one rise time after the ramp clears the attempt count.
// - with ignore set, a fault present at enable blocks start-up.
module pmbov_core #(
  parameter int NUM_PHASES  = 4,
  parameter int REL_FRAC    = 9,
  parameter int OFFSET_MIN  = -256,
  parameter int OFFSET_MAX  = 255,
  parameter int NVM_QUANT   = 2
) (
  // core clock and reset
  input  wire logic                       clk,
  input  wire logic                       reset,
  // link side command port
  input  wire logic                       link_clk,
  input  wire logic                       cmd_valid,
  input  wire pmbov_pkg::pmbov_cmd_t      cmd,
  output logic                            cmd_ready,
  output logic                            rsp_valid,
  output pmbov_pkg::pmbov_rsp_t           rsp,
  // converter context
  input  wire logic                       ov_comparator_raw,
  input  wire logic                       output_enable,
  input  wire logic                       vout_mode_absolute,
  input  wire logic [15:0]                vout_command,
  input  wire logic [23:0]                ton_rise_cycles,
  input  wire logic                       clear_faults,
  // stored defaults
  input  wire logic                       nvm_restore,
  input  wire logic [10:0]                nvm_offset_mantissa,
  input  wire logic [15:0]                nvm_ov_threshold,
  input  wire logic [7:0]                 nvm_ov_action,
  // results
  output logic                            stage_on,
  output logic [11:0]                     ov_trip_permille,
  output logic [NUM_PHASES*11-1:0]        phase_offset,
  output pmbov_pkg::pmbov_status_t        status,
  output logic                            host_notify
);

  // refuse at elaboration what the two-bit phase index cannot serve
  if (NUM_PHASES < 1 || NUM_PHASES > 4 || REL_FRAC > 15 ||
      OFFSET_MIN > OFFSET_MAX || NVM_QUANT > 10) begin : g_param_check
    $error("pmbov_core: unsupported parameters");
  end

  // smallest step not below val/den; zero when above the top step
  function automatic logic [11:0] round_up_step(
      input logic [15:0] val, input logic [15:0] den,
      input logic [11:0] base, input logic [11:0] inc, input int num);
    logic [31:0] lhs;
    logic [11:0] step;
    logic [11:0] r;
    lhs = 32'(val) * pmbov_pkg::PERMILLE;
    r   = 12'h000;
    for (int i = 15; i >= 0; i--) begin
      step = 12'(base + 12'(i) * inc);
      if (i < num && 32'(step) * 32'(den) >= lhs)
        r = step;
    end
    return r;
  endfunction

  function automatic logic in_offset_range(input logic signed [15:0] v);
    return v >= 16'(OFFSET_MIN) && v <= 16'(OFFSET_MAX);
  endfunction

  // ---------------- link domain ----------------
  pmbov_pkg::pmbov_cmd_t link_cmd;
  logic                  link_busy;
  logic                  req_tgl;
  logic                  ack_s1, ack_s2, ack_seen;
  logic                  ack_tgl;
  pmbov_pkg::pmbov_rsp_t core_rsp;

  assign cmd_ready = ~link_busy;

  // command held stable in link_cmd until the core acknowledges
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      link_cmd  <= '0;
      link_busy <= 1'b0;
      req_tgl   <= 1'b0;
    end else if (cmd_valid && !link_busy) begin
      link_cmd  <= cmd;
      link_busy <= 1'b1;
      req_tgl   <= ~req_tgl;
    end else if (link_busy && ack_s2 != ack_seen) begin
      link_busy <= 1'b0;
    end
  end

  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      ack_s1   <= 1'b0;
      ack_s2   <= 1'b0;
      ack_seen <= 1'b0;
    end else begin
      ack_s1   <= ack_tgl;
      ack_s2   <= ack_s1;
      ack_seen <= ack_s2;
    end
  end

  // answer word is stable in core_rsp while the ack toggle crosses
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      rsp_valid <= 1'b0;
      rsp       <= '0;
    end else begin
      rsp_valid <= link_busy && ack_s2 != ack_seen;
      if (link_busy && ack_s2 != ack_seen)
        rsp <= core_rsp;
    end
  end

  // ---------------- core domain ----------------
  logic req_s1, req_s2, req_seen, req_new;
  logic ov_s1, ov_sync;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      req_s1   <= 1'b0;
      req_s2   <= 1'b0;
      req_seen <= 1'b0;
      ov_s1    <= 1'b0;
      ov_sync  <= 1'b0;
    end else begin
      req_s1   <= req_tgl;
      req_s2   <= req_s1;
      req_seen <= req_s2;
      ov_s1    <= ov_comparator_raw;
      ov_sync  <= ov_s1;
    end
  end
  assign req_new = req_s2 != req_seen;

  logic [10:0] offset_man [NUM_PHASES];
  logic [15:0] ov_threshold;
  logic [7:0]  ov_action;
  logic        load_pending;
  logic        invalid_write;

  // decode of the held command
  logic               is_all;
  logic               phase_ok;
  logic [1:0]         phase_idx;
  logic signed [15:0] wr_man;
  logic signed [15:0] wr_share;
  logic               offset_ok;
  logic [15:0]        den;
  logic               thresh_ok;
  logic               action_ok;
  logic signed [15:0] rd_total;

  always_comb begin
    is_all    = link_cmd.phase == pmbov_pkg::PHASE_ALL;
    phase_ok  = is_all || link_cmd.phase < 8'(NUM_PHASES);
    phase_idx = is_all ? 2'h0 : link_cmd.phase[1:0];
    wr_man    = 16'($signed(link_cmd.data[pmbov_pkg::MAN_MSB:0]));
    wr_share  = is_all ? 16'(wr_man / NUM_PHASES) : wr_man;
    offset_ok = phase_ok && in_offset_range(wr_share) &&
                link_cmd.data[pmbov_pkg::EXP_MSB:pmbov_pkg::EXP_LSB]
                  == pmbov_pkg::EXP_RESET;
    den       = vout_mode_absolute ? vout_command : 16'(1 << REL_FRAC);
    thresh_ok = round_up_step(link_cmd.data, den, pmbov_pkg::OV_RUN_MIN,
                  pmbov_pkg::OV_RUN_INC, pmbov_pkg::OV_RUN_NUM) != '0;
    action_ok = link_cmd.data[pmbov_pkg::ACT_MSB:pmbov_pkg::ACT_LSB]
                  != pmbov_pkg::ACTION_INVALID;
    rd_total  = 16'($signed(offset_man[0])) * 16'(NUM_PHASES);
    if (rd_total > 16'sd1023)
      rd_total = 16'sd1023;
    else if (rd_total < -16'sd1024)
      rd_total = -16'sd1024;
  end

  // register writes; stored defaults load one cycle after reset release
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NUM_PHASES; i++)
        offset_man[i] <= '0;
      ov_threshold  <= '0;
      ov_action     <= '0;
      load_pending  <= 1'b1;
      invalid_write <= 1'b0;
    end else begin
      invalid_write <= 1'b0;
      if (load_pending || nvm_restore) begin
        load_pending <= 1'b0;
        for (int i = 0; i < NUM_PHASES; i++)
          offset_man[i] <= nvm_offset_mantissa &
                           ~11'((1 << NVM_QUANT) - 1);
        ov_threshold <= nvm_ov_threshold;
        ov_action    <= nvm_ov_action;
      end else if (req_new && link_cmd.write) begin
        unique case (link_cmd.code)
          pmbov_pkg::CMD_OFFSET: begin
            if (!offset_ok)
              invalid_write <= 1'b1;
            else if (is_all)
              for (int i = 0; i < NUM_PHASES; i++)
                offset_man[i] <= wr_share[10:0];
            else
              offset_man[phase_idx] <= wr_share[10:0];
          end
          pmbov_pkg::CMD_OV_LIMIT: begin
            if (thresh_ok)
              ov_threshold <= link_cmd.data;
            else
              invalid_write <= 1'b1;
          end
          pmbov_pkg::CMD_OV_ACTION: begin
            if (action_ok)
              ov_action <= link_cmd.data[7:0];
            else
              invalid_write <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  // read answer and toggle ack in the same cycle; the word settles before the toggle crosses
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      core_rsp <= '0;
      ack_tgl  <= 1'b0;
    end else if (req_new) begin
      ack_tgl        <= ~ack_tgl;
      core_rsp.error <= 1'b0;
      core_rsp.data  <= '0;
      unique case (link_cmd.code)
        pmbov_pkg::CMD_OFFSET: begin
          core_rsp.error <= !phase_ok;
          core_rsp.data  <= {pmbov_pkg::EXP_RESET,
                            is_all ? rd_total[10:0]
                                   : offset_man[phase_idx]};
        end
        pmbov_pkg::CMD_OV_LIMIT:  core_rsp.data <= ov_threshold;
        pmbov_pkg::CMD_OV_ACTION: core_rsp.data <= {8'h00, ov_action};
        default:                  core_rsp.error <= 1'b1;
      endcase
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_PHASES; i++)
      phase_offset[i*11 +: 11] = offset_man[i];
  end

  // trip point as per mille of the command, recomputed each cycle so a
  // new command or mode takes effect without a rewrite
  logic [15:0] trip_den;
  assign trip_den = vout_mode_absolute ? vout_command : 16'(1 << REL_FRAC);

  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      ov_trip_permille <= pmbov_pkg::OV_MAX;
    else if (stage_on)
      ov_trip_permille <= round_up_step(ov_threshold, trip_den,
                            pmbov_pkg::OV_RUN_MIN, pmbov_pkg::OV_RUN_INC,
                            pmbov_pkg::OV_RUN_NUM);
    else
      ov_trip_permille <= round_up_step(ov_threshold, trip_den,
                            pmbov_pkg::OV_OFF_MIN, pmbov_pkg::OV_OFF_INC,
                            pmbov_pkg::OV_OFF_NUM);
  end

  // fault response sequencer
  pmbov_pkg::pmbov_state_t state;
  logic [2:0]   attempts;
  logic [26:0]  tcnt;
  logic [23:0]  rise;
  logic [1:0]   act_sel;
  logic [2:0]   retry;
  logic [2:0]   wait_mult;
  logic         fault_shut;
  logic         may_retry;

  assign rise       = ton_rise_cycles == '0 ? 24'h000001 : ton_rise_cycles;
  assign act_sel    = ov_action[pmbov_pkg::ACT_MSB:pmbov_pkg::ACT_LSB];
  assign retry      = ov_action[pmbov_pkg::RETRY_MSB:pmbov_pkg::RETRY_LSB];
  assign wait_mult  = ov_action[pmbov_pkg::WAIT_MSB:0] == '0 ? 3'h1
                      : ov_action[pmbov_pkg::WAIT_MSB:0];
  assign fault_shut = ov_sync && act_sel != pmbov_pkg::ACTION_IGNORE;
  assign may_retry  = retry == pmbov_pkg::RETRY_FOREVER ||
                      (retry != pmbov_pkg::RETRY_LATCH && attempts < retry);
  assign stage_on   = state == pmbov_pkg::PMBOV_RISE ||
                      state == pmbov_pkg::PMBOV_CHECK ||
                      state == pmbov_pkg::PMBOV_ON;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state    <= pmbov_pkg::PMBOV_OFF;
      attempts <= '0;
      tcnt     <= '0;
    end else if (!output_enable) begin
      state    <= pmbov_pkg::PMBOV_OFF;
      attempts <= '0;
      tcnt     <= '0;
    end else begin
      tcnt <= tcnt + 27'h1;
      unique case (state)
        pmbov_pkg::PMBOV_OFF: begin
          tcnt <= '0;
          if (!(ov_sync && act_sel == pmbov_pkg::ACTION_IGNORE))
            state <= pmbov_pkg::PMBOV_RISE;
        end
        pmbov_pkg::PMBOV_RISE, pmbov_pkg::PMBOV_CHECK,
        pmbov_pkg::PMBOV_ON: begin
          if (fault_shut) begin
            tcnt  <= '0;
            state <= may_retry ? pmbov_pkg::PMBOV_WAIT
                               : pmbov_pkg::PMBOV_LATCHED;
          end else if (state != pmbov_pkg::PMBOV_ON &&
                       tcnt >= 27'(rise) - 27'h1) begin
            tcnt  <= '0;
            state <= state == pmbov_pkg::PMBOV_RISE ? pmbov_pkg::PMBOV_CHECK
                                                    : pmbov_pkg::PMBOV_ON;
            if (state == pmbov_pkg::PMBOV_CHECK)
              attempts <= '0;
          end
        end
        pmbov_pkg::PMBOV_WAIT: begin
          if (tcnt >= 27'(rise) * 27'(wait_mult) - 27'h1) begin
            tcnt  <= '0;
            state <= pmbov_pkg::PMBOV_RISE;
            if (attempts != pmbov_pkg::RETRY_FOREVER)
              attempts <= attempts + 3'h1;
          end
        end
        pmbov_pkg::PMBOV_LATCHED: tcnt <= '0;
        default: state <= pmbov_pkg::PMBOV_OFF;
      endcase
    end
  end

  // sticky status; a new event wins over a clear in the same cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      status <= '0;
    else begin
      if (clear_faults)
        status <= '0;
      if (ov_sync) begin
        status.byte_vout_ov <= 1'b1;
        status.word_vout    <= 1'b1;
        status.overvoltage_threshold_field     <= 1'b1;
      end
      if (invalid_write)
        status.cml_invalid_data <= 1'b1;
    end
  end
  assign host_notify = |status;

  // ---------------- checks ----------------
  property p_exp_fixed;
    @(posedge clk) disable iff (reset)
    req_new && link_cmd.code == pmbov_pkg::CMD_OFFSET |=>
      core_rsp.data[15:11] == 5'h1C;
  endproperty
  a_exp_fixed: assert property (p_exp_fixed)
    else $error("offset exponent not 11100b");

  property p_invalid_flag;
    @(posedge clk) disable iff (reset || load_pending || nvm_restore)
    req_new && link_cmd.write && link_cmd.code == pmbov_pkg::CMD_OV_ACTION
      && link_cmd.data[7:6] == 2'h3 |=> ##1 status.cml_invalid_data;
  endproperty
  a_invalid_flag: assert property (p_invalid_flag)
    else $error("invalid action write not flagged");

  property p_action_kept;
    @(posedge clk) disable iff (reset || nvm_restore)
    req_new && link_cmd.write && link_cmd.code == pmbov_pkg::CMD_OV_ACTION
      && link_cmd.data[7:6] == 2'h3 && !load_pending |=> $stable(ov_action);
  endproperty
  a_action_kept: assert property (p_action_kept)
    else $error("refused action byte was stored");

  property p_shutdown;
    @(posedge clk) disable iff (reset)
    stage_on && output_enable && ov_sync && act_sel != 2'h0 |=> !stage_on;
  endproperty
  a_shutdown: assert property (p_shutdown)
    else $error("stage still on after overvoltage shutdown");

  property p_status_set;
    @(posedge clk) disable iff (reset)
    ov_sync |=> status.byte_vout_ov && status.word_vout && status.overvoltage_threshold_field
      && host_notify;
  endproperty
  a_status_set: assert property (p_status_set)
    else $error("overvoltage status not set");

  property p_ignore_block;
    @(posedge clk) disable iff (reset)
    state == pmbov_pkg::PMBOV_OFF && ov_sync && act_sel == 2'h0 |=>
      state == pmbov_pkg::PMBOV_OFF;
  endproperty
  a_ignore_block: assert property (p_ignore_block)
    else $error("started into a present overvoltage");

  property p_off_steps;
    @(posedge clk) disable iff (reset)
    ##1 !$past(stage_on) |-> ov_trip_permille == 12'd0 ||
      (ov_trip_permille >= 12'd1100 && ov_trip_permille % 12'd100 == 0);
  endproperty
  a_off_steps: assert property (p_off_steps)
    else $error("trip point off the 10 percent grid");

  property p_run_steps;
    @(posedge clk) disable iff (reset)
    ##1 $past(stage_on) |-> ov_trip_permille == 12'd0 ||
      (ov_trip_permille >= 12'd1050 && ov_trip_permille <= 12'd1400 &&
       (ov_trip_permille - 12'd1050) % 12'd25 == 0);
  endproperty
  a_run_steps: assert property (p_run_steps)
    else $error("trip point off the 2.5 percent grid");

  property p_success_clear;
    @(posedge clk) disable iff (reset)
    state == pmbov_pkg::PMBOV_CHECK && !fault_shut && output_enable &&
      tcnt >= 27'(rise) - 27'h1 |=>
      attempts == 3'h0 && state == pmbov_pkg::PMBOV_ON;
  endproperty
  a_success_clear: assert property (p_success_clear)
    else $error("restart success did not clear attempts");

  property p_rsp_pulse;
    @(posedge link_clk) disable iff (reset)
    rsp_valid |=> !rsp_valid;
  endproperty
  a_rsp_pulse: assert property (p_rsp_pulse)
    else $error("answer strobe longer than one cycle");

  c_latch:   cover property (@(posedge clk) disable iff (reset)
                 state == pmbov_pkg::PMBOV_LATCHED);
  c_retry:   cover property (@(posedge clk) disable iff (reset)
                 state == pmbov_pkg::PMBOV_WAIT ##1
                 state == pmbov_pkg::PMBOV_WAIT);
  c_success: cover property (@(posedge clk) disable iff (reset)
                 state == pmbov_pkg::PMBOV_CHECK ##1
                 state == pmbov_pkg::PMBOV_ON);
  c_all_wr:  cover property (@(posedge clk) disable iff (reset)
                 req_new && link_cmd.write && is_all &&
                 link_cmd.code == pmbov_pkg::CMD_OFFSET);

endmodule

// >>> tb/pmbov_host_model.sv
`timescale 1ns/1ps
module pmbov_host_model (
  // link side
  input  wire logic                  link_clk,
  input  wire logic                  cmd_ready,
  input  wire logic                  rsp_valid,
  input  wire pmbov_pkg::pmbov_rsp_t rsp,
  // request
  output pmbov_pkg::pmbov_cmd_t      cmd,
  output logic                       cmd_valid
);
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end

  // one word per request; byte commands carry the byte in data[7:0]
  task automatic xfer(input logic w, input logic [7:0] c,
                      input logic [7:0] p, input logic [15:0] d,
                      output pmbov_pkg::pmbov_rsp_t r);
    int k;
    k = 0;
    @(posedge link_clk);
    #1;
    while (cmd_ready !== 1'b1 && k < 20) begin
      @(posedge link_clk);
      #1;
      k++;
    end
    cmd_valid = 1'b1;
    cmd = '{w, c, p, d};
    @(posedge link_clk);
    #1;
    cmd_valid = 1'b0;
    // released lines must not keep the old value
    cmd = ~cmd;
    r = '1;
    k = 0;
    while (rsp_valid !== 1'b1 && k < 20) begin
      @(posedge link_clk);
      #1;
      k++;
    end
    if (k < 20) r = rsp;
  endtask
endmodule

// >>> tb/tb_pmbus_ov_fault_and_offset_cmds.sv
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
  $display("BAD %0t %h %h", $time, (a), (b)); end end
module tb_pmbus_ov_fault_and_offset_cmds;
  logic                     clk = 1'b0;
  logic                     link_clk = 1'b0;
  logic                     reset = 1'b1;
  logic                     cmd_valid, cmd_ready, rsp_valid;
  pmbov_pkg::pmbov_cmd_t    cmd;
  pmbov_pkg::pmbov_rsp_t    rsp, r;
  logic                     ov_raw = 1'b0, oe = 1'b0, absm = 1'b0;
  logic                     clr = 1'b0, restore = 1'b0;
  logic [15:0]              vcmd = 16'h03E8;
  logic [23:0]              rise = 24'h000005;
  logic                     stage_on, host_notify;
  logic [11:0]              trip;
  logic [43:0]              phase_offset;
  pmbov_pkg::pmbov_status_t status;
  int                       errors = 0, compares = 0, n;

  always #2 clk = ~clk;
  // 12 ns offset puts link edges on core falling edges, clear of core rising edges
  initial begin
    #12;
    forever #40 link_clk = ~link_clk;
  end

  pmbov_core pmbov_core_inst (
    .clk(clk), .reset(reset), .link_clk(link_clk),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp(rsp), .ov_comparator_raw(ov_raw),
    .output_enable(oe), .vout_mode_absolute(absm),
    .vout_command(vcmd), .ton_rise_cycles(rise), .clear_faults(clr),
    .nvm_restore(restore), .nvm_offset_mantissa(11'h017),
    .nvm_ov_threshold(16'h0280), .nvm_ov_action(8'h4A),
    .stage_on(stage_on), .ov_trip_permille(trip),
    .phase_offset(phase_offset), .status(status),
    .host_notify(host_notify));

  pmbov_host_model pmbov_host_model_inst (
    .link_clk(link_clk), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp(rsp), .cmd(cmd), .cmd_valid(cmd_valid));

  task automatic xf(input logic w, input logic [7:0] c,
                    input logic [7:0] p, input logic [15:0] d);
    pmbov_host_model_inst.xfer(w, c, p, d, r);
  endtask

  task automatic clks(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic clear_pulse;
    // let a just-released comparator leave the synchroniser first
    clks(3);
    clr = 1'b1;
    clks(1);
    clr = 1'b0;
    clks(2);
  endtask

  task automatic wait_stage(input logic lvl);
    n = 0;
    while (stage_on !== lvl && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 200) errors++;
  endtask

  task automatic final_report;
    if (errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    #100000;
    errors++;
    final_report;
  end

  initial begin
    // two link cycles so both domains see the reset
    #160;
    clks(1);
    reset = 1'b0;
    clks(4);
    xf(1'b0, pmbov_pkg::CMD_OFFSET, 8'h00, 16'h0000);
    `CHK(r.data, 16'hE014)
    xf(1'b1, pmbov_pkg::CMD_OFFSET, 8'h01, 16'hE064);
    xf(1'b0, pmbov_pkg::CMD_OFFSET, 8'h01, 16'h0000);
    `CHK(r.data, 16'hE064)
    `CHK(phase_offset[21:11], 11'h064)
    xf(1'b1, pmbov_pkg::CMD_OFFSET, pmbov_pkg::PHASE_ALL, 16'hE028);
    `CHK(phase_offset, {4{11'h00A}})
    xf(1'b0, pmbov_pkg::CMD_OFFSET, pmbov_pkg::PHASE_ALL, 16'h0000);
    `CHK(r.data, 16'hE028)
    xf(1'b1, pmbov_pkg::CMD_OFFSET, 8'h00, 16'hE805);
    clks(3);
    `CHK(status.cml_invalid_data, 1'b1)
    `CHK(phase_offset[10:0], 11'h00A)
    clear_pulse;
    restore = 1'b1;
    clks(1);
    restore = 1'b0;
    clks(3);
    `CHK(phase_offset[10:0], 11'h014)
    `CHK(trip, 12'h514)
    xf(1'b0, 8'h42, 8'h00, 16'h0000);
    `CHK(r.error, 1'b1)
    xf(1'b1, pmbov_pkg::CMD_OV_LIMIT, 8'h00, 16'h023E);
    xf(1'b0, pmbov_pkg::CMD_OV_LIMIT, 8'h00, 16'h0000);
    `CHK(r.data, 16'h023E)
    clks(3);
    `CHK(trip, 12'h4B0)
    xf(1'b1, pmbov_pkg::CMD_OV_LIMIT, 8'h00, 16'h0300);
    clks(3);
    `CHK(status.cml_invalid_data, 1'b1)
    clear_pulse;
    absm = 1'b1;
    xf(1'b1, pmbov_pkg::CMD_OV_LIMIT, 8'h00, 16'h046A);
    clks(3);
    `CHK(trip, 12'h4B0)
    xf(1'b1, pmbov_pkg::CMD_OV_ACTION, 8'h00, 16'h00C0);
    xf(1'b0, pmbov_pkg::CMD_OV_ACTION, 8'h00, 16'h0000);
    `CHK(r.data, 16'h004A)
    clear_pulse;
    oe = 1'b1;
    wait_stage(1'b1);
    clks(12);
    `CHK(trip, 12'h47E)
    ov_raw = 1'b1;
    wait_stage(1'b0);
    `CHK(status, 4'hE)
    `CHK(host_notify, 1'b1)
    // fault gone during the wait: restart succeeds, attempts clear
    ov_raw = 1'b0;
    wait_stage(1'b1);
    `CHK(n >= 9 && n <= 12, 1'b1)
    clks(12);
    `CHK(stage_on, 1'b1)
    // with attempts cleared the one allowed retry is available again
    ov_raw = 1'b1;
    wait_stage(1'b0);
    wait_stage(1'b1);
    `CHK(n >= 9 && n <= 12, 1'b1)
    wait_stage(1'b0);
    clks(60);
    `CHK(stage_on, 1'b0)
    oe = 1'b0;
    ov_raw = 1'b0;
    clear_pulse;
    xf(1'b1, pmbov_pkg::CMD_OV_ACTION, 8'h00, 16'h0000);
    clks(1);
    ov_raw = 1'b1;
    clks(4);
    `CHK(status.overvoltage_threshold_field, 1'b1)
    oe = 1'b1;
    clks(30);
    `CHK(stage_on, 1'b0)
    final_report;
  end
endmodule
